// ==== gpio_and_result_register_map_tb.sv ====
// Self-checking bench for the result and pin register map
`timescale 1ns/1ps
module gpio_and_result_register_map_tb;
	logic                         clk;
	logic                         reset;
	logic                         word_valid;
	logic [15:0]                  word;
	logic [4:0]                   read_addr;
	logic [11:0]                  read_data_q;
	logic                         result_valid;
	gpio_result_pkg::result_upd_s result_upd;
	wire logic [3:0]              pin_in;
	logic [3:0]                   pin_out;
	logic [3:0]                   pin_oe;
	logic [3:0]                   pin_drv;
	logic                         alert_src_q;
	logic [2:0]                   aux_route_q;
	logic [11:0]                  d;
	int                           errors;
	int                           comparisons;

	// Wire level: design drive wins where enabled
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drv);

	gpio_result_regs uut (
		.clk(clk), .reset(reset), .word_valid(word_valid), .word(word),
		.read_addr(read_addr), .read_data_q(read_data_q),
		.result_valid(result_valid), .result_upd(result_upd),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.alert_src_q(alert_src_q), .aux_route_q(aux_route_q)
	);

	host_model host (
		.clk(clk), .word_valid(word_valid), .word(word),
		.read_addr(read_addr), .read_data_q(read_data_q)
	);

	// ============================================================
	// Compare, read and verdict tasks
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic rd_chk(input logic [4:0] a, input logic [11:0] exp);
		host.read_reg(a, d);
		check(d, exp);
	endtask : rd_chk

	// Filter and alert path need up to seven edges, eight leaves margin
	task automatic pin_case(input logic [7:0] cfg, input logic [3:0] drv,
		input logic al, input logic [11:0] exp);
		host.write_ext(4'hF, 4'h0, cfg);
		pin_drv = drv;
		repeat (8) @(posedge clk);
		#1 check(12'(alert_src_q), 12'(al));
		rd_chk(5'h1D, exp);
	endtask : pin_case

	task automatic complete_run;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run

	// ============================================================
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		#20000;
		errors++;
		complete_run();
	end

	// ============================================================
	// Tests
	initial begin
		reset = 1'b1;
		result_valid = 1'b0;
		result_upd = '0;
		pin_drv = 4'h5;
		errors = 0;
		comparisons = 0;
		repeat (2) @(posedge clk);
		#1 reset = 1'b0;
		for (int a = 'h13; a <= 'h1D; a++) begin
			rd_chk(5'(a), 12'h000);
		end
		$display("test reset_values done");
		// Last update aims at a config address and must be dropped
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			#1 result_valid = 1'b1;
			result_upd = {5'(5'h14 + i), 12'(12'h123 + i * 12'h111)};
		end
		@(posedge clk);
		#1 result_valid = 1'b0;
		host.write_ext(4'hF, 4'h4, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			rd_chk(5'(5'h14 + i), (i == 7) ? 12'h000 :
				12'(12'h123 + i * 12'h111));
		end
		// Address is held, so the update is read back the very next cycle
		rd_chk(5'h14, 12'h123);
		@(posedge clk);
		#1 result_valid = 1'b1;
		result_upd = {5'h14, 12'h5A5};
		@(posedge clk);
		#1 result_valid = 1'b0;
		rd_chk(5'h14, 12'h5A5);
		$display("test results done");
		host.write_ext(4'hF, 4'h0, 8'hA5);
		host.write_ext(4'hF, 4'h1, 8'hFF);
		host.write_ext(4'hE, 4'h0, 8'h33);
		rd_chk(5'h1B, 12'h0A5);
		rd_chk(5'h1C, 12'h0F7);
		check(12'(pin_oe), 12'h000);
		check(12'(aux_route_q), 12'h005);
		$display("test config done");
		host.write_ext(4'hF, 4'h0, 8'h88);
		host.write_ext(4'hF, 4'h1, 8'h80);
		host.write_ext(4'hF, 4'h2, 8'hAF);
		repeat (3) @(posedge clk);
		#1 check(12'({pin_oe, pin_out}), 12'h0FA);
		rd_chk(5'h1D, 12'h0A0);
		$display("test outputs done");
		pin_case(8'hF8, 4'h0, 1'b0, 12'h020);
		pin_case(8'hF8, 4'h8, 1'b1, 12'h0A0);
		pin_case(8'hB8, 4'h0, 1'b1, 12'h020);
		pin_case(8'hA8, 4'h0, 1'b0, 12'h020);
		host.write_ext(4'hF, 4'h1, 8'h87);
		pin_case(8'h88, 4'h1, 1'b1, 12'h0B0);
		$display("test inputs done");
		complete_run();
	end
endmodule : gpio_and_result_register_map_tb

// ==== gpio_result_pkg.sv ====
// Constants and types for the measurement result and pin register map
// ============================================================
// Function
// - Auxiliary input two and three results read at addresses 10100, 10101.
// - Battery input one and two results read at addresses 10110, 10111.
// - Single-ended and differential temperature results read at 11000, 11001.
// - First pressure result reads at address 11010.
// - Result registers are read-only and read zero after reset.
// - Extended writes carry prefix 1111b in the top four word bits.
// - Next four bits pick the pin register; low eight bits are data.
// - First pin config register: write 0000, read 11011, resets zero.
// - Second pin config register: write 0001, read 11100, resets zero.
// - Pin data register: write 0010, read 11101, bits 7..4 pins 1..4.
// - Alert enable bits 4 and 0 let a pin raise the alert.
// - Direction bits 5 and 1: zero output, one input.
// - Polarity bits 6 and 2: zero active low, one active high.
// - Function select bits pick analog input or pin; pin four has none.
// - Second register: pin three in bits 7..4, pin four 2..0, bit 3 unused.
package gpio_result_pkg;

	// ============================================================
	// Word format
	localparam int         WORD_W      = 16;
	localparam int         PREFIX_MSB  = 15;
	localparam int         PREFIX_LSB  = 12;
	localparam int         SUB_MSB     = 11;
	localparam int         SUB_LSB     = 8;
	localparam logic [3:0] EXT_PREFIX  = 4'hF;
	localparam int         RES_W       = 12;
	localparam int         ADDR_W      = 5;

	// ============================================================
	// Read addresses
	localparam logic [4:0] RD_AUX_2    = 5'h14;
	localparam logic [4:0] RD_AUX_3    = 5'h15;
	localparam logic [4:0] RD_BAT_1    = 5'h16;
	localparam logic [4:0] RD_BAT_2    = 5'h17;
	localparam logic [4:0] RD_TEMP_SE  = 5'h18;
	localparam logic [4:0] RD_TEMP_DF  = 5'h19;
	localparam logic [4:0] RD_PRESS1   = 5'h1A;
	localparam logic [4:0] RD_CFG_A    = 5'h1B;
	localparam logic [4:0] RD_CFG_B    = 5'h1C;
	localparam logic [4:0] RD_DATA     = 5'h1D;
	localparam int         NUM_RES     = 7;

	// ============================================================
	// Extended write addresses
	localparam logic [3:0] WR_CFG_A    = 4'h0;
	localparam logic [3:0] WR_CFG_B    = 4'h1;
	localparam logic [3:0] WR_DATA     = 4'h2;

	// ============================================================
	// Field positions and reset values
	localparam int         HI_NIB      = 4;
	localparam int         F_ALERT     = 0;
	localparam int         F_DIR       = 1;
	localparam int         F_POL       = 2;
	localparam int         F_SEL       = 3;
	localparam logic [7:0] CFG_RST     = 8'h00;
	localparam logic [3:0] DATA_RST    = 4'h0;
	localparam logic [7:0] CFG_B_MASK  = 8'hF7;
	localparam logic [11:0] RES_RST    = 12'h000;

	// ============================================================
	// Types
	typedef struct packed {
		logic       sel;
		logic       pol;
		logic       dir;
		logic       alert;
	} pin_cfg_s;

	typedef struct packed {
		logic [4:0]  addr;
		logic [11:0] value;
	} result_upd_s;

endpackage : gpio_result_pkg

// ==== gpio_result_regs.sv ====
// Result registers and pin register block behind the serial word port
`timescale 1ns/1ps
module gpio_result_regs (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset,
	// Deserialised data word from the serial port
	input  wire logic                         word_valid,
	input  wire logic [15:0]                  word,
	// Read address held by the control register
	input  wire logic [4:0]                   read_addr,
	output logic      [11:0]                  read_data_q,
	// Converter results
	input  wire logic                         result_valid,
	input  wire gpio_result_pkg::result_upd_s result_upd,
	// Pins one to four, index 3 is pin one
	input  wire logic [3:0]                   pin_in,
	output logic      [3:0]                   pin_out,
	output logic      [3:0]                   pin_oe,
	// Alert source and analog routing
	output logic                              alert_src_q,
	output logic      [2:0]                   aux_route_q
);

	logic [11:0] res_q [gpio_result_pkg::NUM_RES];
	logic [7:0]  cfg_a_q;
	logic [7:0]  cfg_b_q;
	logic [3:0]  data_q;
	logic [3:0]  level;
	logic [3:0]  active;
	logic [3:0]  data_rd;
	logic [3:0]  cfg_nib [4];
	logic        ext_wr;
	logic [3:0]  sub;
	logic [4:0]  res_idx;
	logic [11:0] rd_d;

	assign ext_wr = word_valid & (word[gpio_result_pkg::PREFIX_MSB:
		gpio_result_pkg::PREFIX_LSB] == gpio_result_pkg::EXT_PREFIX);
	assign sub    = word[gpio_result_pkg::SUB_MSB:gpio_result_pkg::SUB_LSB];

	// ============================================================
	// Result store, written only by the converter
	assign res_idx = result_upd.addr - gpio_result_pkg::RD_AUX_2;

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < gpio_result_pkg::NUM_RES; i++) begin
				res_q[i] <= gpio_result_pkg::RES_RST;
			end
		end else if (result_valid
			&& result_upd.addr >= gpio_result_pkg::RD_AUX_2
			&& result_upd.addr <= gpio_result_pkg::RD_PRESS1) begin
			res_q[res_idx[2:0]] <= result_upd.value;
		end
	end

	// ============================================================
	// Pin registers
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_a_q <= gpio_result_pkg::CFG_RST;
			cfg_b_q <= gpio_result_pkg::CFG_RST;
			data_q  <= gpio_result_pkg::DATA_RST;
		end else if (ext_wr) begin
			case (sub)
				gpio_result_pkg::WR_CFG_A: cfg_a_q <= word[7:0];
				// Bit 3 is not stored, so it always reads zero
				gpio_result_pkg::WR_CFG_B: cfg_b_q <= word[7:0]
					& gpio_result_pkg::CFG_B_MASK;
				gpio_result_pkg::WR_DATA:  data_q <= word[7:4];
				default: ;
			endcase
		end
	end

	// Nibble order: pin one, two, three, four
	assign cfg_nib[3] = cfg_a_q[7:4];
	assign cfg_nib[2] = cfg_a_q[3:0];
	assign cfg_nib[1] = cfg_b_q[7:4];
	assign cfg_nib[0] = cfg_b_q[3:0];

	for (genvar p = 0; p < 4; p++) begin : g_pin
		pin_slice #(.HAS_SELECT(p != 0)) u_pin (
			.clk      (clk),
			.reset    (reset),
			.cfg      (gpio_result_pkg::pin_cfg_s'(cfg_nib[p])),
			.data_bit (data_q[p]),
			.pin_in   (pin_in[p]),
			.pin_out  (pin_out[p]),
			.pin_oe   (pin_oe[p]),
			.level_q  (level[p]),
			.active_q (active[p])
		);
		assign data_rd[p] = cfg_nib[p][gpio_result_pkg::F_DIR]
			? level[p] : data_q[p];
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			alert_src_q <= 1'b0;
			aux_route_q <= 3'h0;
		end else begin
			alert_src_q <= |active;
			aux_route_q <= {cfg_a_q[7], cfg_a_q[3], cfg_b_q[7]};
		end
	end

	// ============================================================
	// Read path: one cycle from address to data
	always_comb begin
		rd_d = 12'h000;
		case (read_addr)
			gpio_result_pkg::RD_AUX_2:   rd_d = res_q[0];
			gpio_result_pkg::RD_AUX_3:   rd_d = res_q[1];
			gpio_result_pkg::RD_BAT_1:   rd_d = res_q[2];
			gpio_result_pkg::RD_BAT_2:   rd_d = res_q[3];
			gpio_result_pkg::RD_TEMP_SE: rd_d = res_q[4];
			gpio_result_pkg::RD_TEMP_DF: rd_d = res_q[5];
			gpio_result_pkg::RD_PRESS1:  rd_d = res_q[6];
			gpio_result_pkg::RD_CFG_A:   rd_d = {4'h0, cfg_a_q};
			gpio_result_pkg::RD_CFG_B:   rd_d = {4'h0, cfg_b_q};
			gpio_result_pkg::RD_DATA:    rd_d = {4'h0, data_rd, 4'h0};
			default:                     rd_d = 12'h000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			read_data_q <= 12'h000;
		end else begin
			read_data_q <= rd_d;
		end
	end

	// ============================================================
	// Checks
	chk_cfg_a_write: assert property (@(posedge clk) disable iff (reset)
		ext_wr && sub == 4'h0 |=> cfg_a_q == $past(word[7:0]))
		else $error("config A write lost");
	chk_cfg_b_bit3: assert property (@(posedge clk) disable iff (reset)
		cfg_b_q[3] == 1'b0)
		else $error("config B bit 3 set");
	chk_non_ext_ignored: assert property (@(posedge clk)
		disable iff (reset)
		word_valid && word[15:12] != 4'hF |=> $stable(cfg_a_q)
		&& $stable(cfg_b_q) && $stable(data_q))
		else $error("plain write touched pin registers");
	chk_data_low_zero: assert property (@(posedge clk) disable iff (reset)
		read_addr == 5'h1D ##1 1'b1 |-> read_data_q[3:0] == 4'h0
		&& read_data_q[11:8] == 4'h0)
		else $error("data register unused bits nonzero");
	chk_result_read: assert property (@(posedge clk) disable iff (reset)
		result_valid && result_upd.addr == 5'h14 ##1 read_addr == 5'h14
		&& !result_valid |=> read_data_q == $past(result_upd.value, 2))
		else $error("aux two result mismatch");
	chk_press_read: assert property (@(posedge clk) disable iff (reset)
		read_addr == 5'h1A |=> read_data_q == $past(res_q[6]))
		else $error("pressure result mismatch");
	chk_out_drive: assert property (@(posedge clk) disable iff (reset)
		cfg_b_q[1] == 1'b0 ##1 cfg_b_q[1] == 1'b0 |-> pin_oe[0])
		else $error("pin four not driven as output");
	chk_input_release: assert property (@(posedge clk)
		disable iff (reset)
		cfg_a_q[5] ##1 cfg_a_q[5] |-> !pin_oe[3])
		else $error("input pin one driven");
	chk_alert_mask: assert property (@(posedge clk) disable iff (reset)
		(cfg_a_q[4] | cfg_a_q[0] | cfg_b_q[4] | cfg_b_q[0]) == 1'b0
		[*3] |=> !alert_src_q)
		else $error("alert raised while all masked");
	chk_result_reset: assert property (@(posedge clk)
		$fell(reset) |-> res_q[2] == 12'h000)
		else $error("result not zero after reset");

	// ============================================================
	// Checks: write port

	chk_cfg_b_write: assert property (@(posedge clk)
		disable iff (reset) ext_wr && sub == gpio_result_pkg::WR_CFG_B
		|=> cfg_b_q == ($past(word[7:0]) & gpio_result_pkg::CFG_B_MASK))
		else $error("config B write lost");

	chk_data_write: assert property (@(posedge clk)
		disable iff (reset) ext_wr && sub == gpio_result_pkg::WR_DATA
		|=> data_q == $past(word[7:4]))
		else $error("data register write lost");

	chk_bad_sub: assert property (@(posedge clk)
		disable iff (reset) ext_wr && sub > gpio_result_pkg::WR_DATA
		|=> $stable(cfg_a_q) && $stable(cfg_b_q) && $stable(data_q))
		else $error("unmapped extended write took effect");

	chk_idle_hold: assert property (@(posedge clk)
		disable iff (reset) !word_valid
		|=> $stable(cfg_a_q) && $stable(cfg_b_q) && $stable(data_q))
		else $error("pin register changed without a write");

	// ============================================================
	// Checks: read port

	chk_cfg_a_read: assert property (@(posedge clk)
		disable iff (reset) read_addr == gpio_result_pkg::RD_CFG_A
		|=> read_data_q == {4'h0, $past(cfg_a_q)})
		else $error("config A read mismatch");

	chk_cfg_b_read: assert property (@(posedge clk)
		disable iff (reset) read_addr == gpio_result_pkg::RD_CFG_B
		|=> read_data_q == {4'h0, $past(cfg_b_q)})
		else $error("config B read mismatch");

	chk_aux_three_read: assert property (@(posedge clk)
		disable iff (reset) read_addr == gpio_result_pkg::RD_AUX_3
		|=> read_data_q == $past(res_q[1]))
		else $error("aux three result mismatch");

	chk_bat_two_read: assert property (@(posedge clk)
		disable iff (reset) read_addr == gpio_result_pkg::RD_BAT_2
		|=> read_data_q == $past(res_q[3]))
		else $error("battery two result mismatch");

	chk_temp_se_read: assert property (@(posedge clk)
		disable iff (reset) read_addr == gpio_result_pkg::RD_TEMP_SE
		|=> read_data_q == $past(res_q[4]))
		else $error("single ended temperature mismatch");

	chk_temp_df_read: assert property (@(posedge clk)
		disable iff (reset) read_addr == gpio_result_pkg::RD_TEMP_DF
		|=> read_data_q == $past(res_q[5]))
		else $error("differential temperature mismatch");

	chk_out_read: assert property (@(posedge clk)
		disable iff (reset) !cfg_b_q[gpio_result_pkg::F_DIR]
		&& read_addr == gpio_result_pkg::RD_DATA
		|=> read_data_q[4] == $past(data_q[0]))
		else $error("output pin four read mismatch");

	chk_in_read: assert property (@(posedge clk)
		disable iff (reset) cfg_a_q[5]
		&& read_addr == gpio_result_pkg::RD_DATA
		|=> read_data_q[7] == $past(level[3]))
		else $error("input pin one read mismatch");

	// ============================================================
	// Checks: result store

	chk_result_store: assert property (@(posedge clk)
		disable iff (reset) result_valid
		&& result_upd.addr == gpio_result_pkg::RD_BAT_1
		|=> res_q[2] == $past(result_upd.value))
		else $error("battery one result not stored");

	chk_press_store: assert property (@(posedge clk)
		disable iff (reset) result_valid
		&& result_upd.addr == gpio_result_pkg::RD_PRESS1
		|=> res_q[6] == $past(result_upd.value))
		else $error("pressure result not stored");

	chk_result_hold: assert property (@(posedge clk)
		disable iff (reset) !result_valid |=> $stable(res_q[0])
		&& $stable(res_q[1]) && $stable(res_q[2]) && $stable(res_q[3])
		&& $stable(res_q[4]) && $stable(res_q[5]) && $stable(res_q[6]))
		else $error("result changed without an update");

	chk_result_range: assert property (@(posedge clk)
		disable iff (reset) result_valid
		&& (result_upd.addr < gpio_result_pkg::RD_AUX_2
		|| result_upd.addr > gpio_result_pkg::RD_PRESS1)
		|=> $stable(res_q[0]) && $stable(res_q[1]) && $stable(res_q[2])
		&& $stable(res_q[3]) && $stable(res_q[4]) && $stable(res_q[5])
		&& $stable(res_q[6]))
		else $error("out of range update stored");

	// ============================================================
	// Checks: pins

	chk_unsel_release: assert property (@(posedge clk)
		disable iff (reset) !cfg_a_q[7] ##1 !cfg_a_q[7] |-> !pin_oe[3])
		else $error("analog pin one driven");

	chk_out_follow: assert property (@(posedge clk)
		disable iff (reset) 1'b1 |=> pin_out == $past(data_q))
		else $error("pin drive does not follow data register");

	chk_output_no_alert: assert property (@(posedge clk)
		disable iff (reset) (cfg_a_q[5] | cfg_a_q[1] | cfg_b_q[5]
		| cfg_b_q[1]) == 1'b0 [*3] |=> !alert_src_q)
		else $error("alert raised with no input pin");

	// A level change must have been seen by both late filter stages
	chk_level_filter: assert property (@(posedge clk)
		disable iff (reset) $changed(level[0])
		|-> level[0] == $past(pin_in[0], 4)
		&& level[0] == $past(pin_in[0], 3))
		else $error("pin four level bypassed its filter");

	chk_route_follow: assert property (@(posedge clk)
		disable iff (reset) 1'b1 |=> aux_route_q == {$past(cfg_a_q[7]),
		$past(cfg_a_q[3]), $past(cfg_b_q[7])})
		else $error("analog routing does not follow select bits");

	chk_reset_idle: assert property (@(posedge clk)
		$fell(reset) |-> pin_oe == 4'h0 && !alert_src_q
		&& read_data_q == 12'h000)
		else $error("outputs not idle after reset");

	cov_ext_data_write: cover property (@(posedge clk) disable iff (reset)
		ext_wr && sub == 4'h2);
	cov_alert: cover property (@(posedge clk) disable iff (reset)
		$rose(alert_src_q));
	cov_result_read: cover property (@(posedge clk) disable iff (reset)
		result_valid ##1 read_addr == result_upd.addr);
	cov_bad_sub: cover property (@(posedge clk) disable iff (reset)
		ext_wr && sub > gpio_result_pkg::WR_DATA);
	cov_input_read: cover property (@(posedge clk) disable iff (reset)
		read_addr == gpio_result_pkg::RD_DATA && cfg_a_q[5]);

endmodule : gpio_result_regs

// ==== host_model.sv ====
// Host processor model: extended word writes and addressed reads
`timescale 1ns/1ps
module host_model (
	// Clock
	input  wire logic        clk,
	// Word and read ports
	output logic             word_valid,
	output logic      [15:0] word,
	output logic      [4:0]  read_addr,
	input  wire logic [11:0] read_data_q
);
	initial begin
		word_valid = 1'b0;
		word = 16'h0000;
		read_addr = 5'h00;
	end

	// ============================================================
	// Extended write: prefix, register select, eight data bits
	task automatic write_ext(input logic [3:0] pfx, input logic [3:0] sub,
		input logic [7:0] val);
		@(posedge clk);
		#1 word_valid = 1'b1;
		word = {pfx, sub, val};
		@(posedge clk);
		#1 word_valid = 1'b0;
		// Stale word is inverted so it cannot pass for a new one
		word = ~word;
	endtask : write_ext

	// ============================================================
	// Read: address first, answer one edge later
	task automatic read_reg(input logic [4:0] a, output logic [11:0] d);
		@(posedge clk);
		#1 read_addr = a;
		@(posedge clk);
		#1 d = read_data_q;
	endtask : read_reg
endmodule : host_model

// ==== pin_slice.sv ====
// One shared pin: input filter, drive and alert qualification
`timescale 1ns/1ps
module pin_slice #(
	parameter bit HAS_SELECT = 1'b1
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset,
	// Settings
	input  wire gpio_result_pkg::pin_cfg_s cfg,
	input  wire logic                      data_bit,
	// Pin
	input  wire logic                      pin_in,
	output logic                           pin_out,
	output logic                           pin_oe,
	// Status
	output logic                           level_q,
	output logic                           active_q
);

	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	logic is_pin;

	// Pin four has no analog alternative, so it is always a pin
	assign is_pin = HAS_SELECT ? cfg.sel : 1'b1;

	// ============================================================
	// Input filter: a change counts once two late stages agree
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			level_q <= 1'b0;
		end else if (sync2_q == sync3_q) begin
			level_q <= sync3_q;
		end
	end

	// ============================================================
	// Drive and alert
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_oe  <= 1'b0;
			pin_out <= 1'b0;
		end else begin
			pin_oe  <= is_pin & ~cfg.dir;
			pin_out <= data_bit;
		end
	end

	// Polarity one means a high level is the active state
	always_ff @(posedge clk) begin
		if (reset) begin
			active_q <= 1'b0;
		end else begin
			active_q <= is_pin & cfg.dir & cfg.alert
				& (level_q == cfg.pol);
		end
	end

endmodule : pin_slice
